/* File: shared/prs_params.svh */
// Offsets, fields, reset values and timing figures of the power, reset and clock sequencer
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
// Clock rate and printed times
`define PRS_CLK_MHZ 125
`define PRS_START_MS 1
`define PRS_LONG_PRESS_MS 5600
`define PRS_HOLD_OFF_MS 2000
`define PRS_MAIN_LOSS_MS 10
// Register offsets (byte addresses)
`define PRS_ADDR_W 8
`define PRS_OFS_CTRL 8'h00
`define PRS_OFS_STATUS 8'h04
`define PRS_OFS_CLKMUL 8'h08
`define PRS_OFS_VREG 8'h0C
`define PRS_OFS_WDOG 8'h10
// CTRL fields
`define PRS_CTRL_SHDN 0
`define PRS_CTRL_USB 1
`define PRS_CTRL_WDEN 2
// STATUS fields
`define PRS_ST_KEY 0
`define PRS_ST_HOLD 1
`define PRS_ST_IOSTRAP 2
`define PRS_ST_SPISTRAP 3
`define PRS_ST_AUDIO 4
`define PRS_ST_REGON 5
`define PRS_ST_CAUSE_LO 8
// VREG fields
`define PRS_VREG_IO33 0
`define PRS_VREG_AV36 1
// Multiplier codes: factor = 1.0 + 0.5 * code
`define PRS_MUL_W 3
`define PRS_MUL_X1 3'h0
`define PRS_MUL_X35 3'h5
`define PRS_MUL_X4 3'h6
// Reset values
`define PRS_WDOG_RST 32'h0000_0000
`define PRS_RDATA_RST 32'h0000_0000
`endif

/* File: shared/prs_pkg.sv */
// Types shared by the power, reset and clock sequencer
package prs_pkg;
  // Regulator power state, one-hot
  typedef enum logic [2:0] {
    PRS_OFF = 3'h1,
    PRS_STARTING = 3'h2,
    PRS_ON = 3'h4
  } prs_pwr_st_t;
  // Last reset cause, one bit each
  typedef enum logic [3:0] {
    PRS_CAUSE_NONE = 4'h0,
    PRS_CAUSE_SUPPLY = 4'h1,
    PRS_CAUSE_LONGKEY = 4'h2,
    PRS_CAUSE_WDOG = 4'h4,
    PRS_CAUSE_EXT = 4'h8
  } prs_cause_t;
endpackage

/* File: design/prs_rst_sync.sv */
// Reset synchroniser: asynchronous assertion, synchronous release
`timescale 1ns/100ps
`default_nettype none
module prs_rst_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_in, // Internal clock
  input wire logic arst_b_in, // Combined reset sources, active low
  output logic rst_b_out // Released reset, from last stage
);
  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  // Shift a one in; only the next stage reads each stage but the last, which drives rst_b_out
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], 1'b1};
  end

  always_ff @(posedge clk_in or negedge arst_b_in) begin
    if (!arst_b_in) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end

  assign rst_b_out = chain_q[STAGES-1];
endmodule
`default_nettype wire

/* File: design/prs_sequencer.sv */
// Power key, reset source and clock multiplier sequencer
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "prs_params.svh"
module prs_sequencer #(
  parameter int START_CYC = `PRS_START_MS * 1000 * `PRS_CLK_MHZ,
  parameter int LONG_CYC = `PRS_LONG_PRESS_MS * 1000 * `PRS_CLK_MHZ,
  parameter int HOLD_CYC = `PRS_HOLD_OFF_MS * 1000 * `PRS_CLK_MHZ,
  parameter int LOSS_CYC = `PRS_MAIN_LOSS_MS * 1000 * `PRS_CLK_MHZ,
  parameter int CNT_W = 32
) (
  input wire logic mclk_in, // 125 MHz clock
  input wire logic rst_b_in, // Always-on power reset, active low
  input wire logic power_key_in, // Power key level
  input wire logic ext_reset_n_in, // External reset pin, active low
  input wire logic core_supply_low_in, // Monitor: core supply under level
  input wire logic main_supply_in, // Main supply present
  input wire logic usb_detect_in, // USB connection detected
  input wire logic io_level_strap_in, // I/O level strap
  input wire logic spi_select_strap_in, // Serial boot strap
  input wire logic usb_class_strap_in, // USB class strap
  input wire logic [`PRS_ADDR_W-1:0] addr_in, // Register address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after read
  output logic regulators_on_out, // Regulator enable
  output logic sys_rst_b_out, // Internal reset, active low
  output logic clk_buf_en_out, // Clock buffer enable
  output logic digital_pd_out, // Digital section powerdown
  output logic [`PRS_MUL_W-1:0] clk_mult_out, // Multiplier code
  output logic io_33v_out, // I/O at 3.3 V when high
  output logic analog_supply_36v_out, // Analog supply at 3.6 V when high
  output logic boot_spi_out, // Try serial memory boot
  output logic usb_audio_out // USB audio class chosen
);
  prs_pkg::prs_pwr_st_t pwr_q, pwr_d;
  logic [CNT_W-1:0] st_cnt_q, st_cnt_d;
  logic [CNT_W-1:0] lp_cnt_q, lp_cnt_d;
  logic [CNT_W-1:0] loss_cnt_q, loss_cnt_d;
  logic lp_done_q, lp_done_d;
  logic lp_fire_q, lp_fire_d;
  logic wd_fire_q, wd_fire_d;
  logic [3:0] cause_q, cause_d;
  logic [31:0] rdata_q, rdata_d;
  logic sys_rst_b;
  logic src_b;
  logic shdn_wr;
  logic ctrl_usb_q, ctrl_usb_d;
  logic ctrl_wden_q, ctrl_wden_d;
  logic [`PRS_MUL_W-1:0] mul_q, mul_d;
  logic [`PRS_MUL_W-1:0] clk_mult_q, clk_mult_d;
  logic io33_q, io33_d;
  logic av36_q, av36_d;
  logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic rel_q;
  logic io_strap_q, io_strap_d;
  logic spi_strap_q, spi_strap_d;
  logic audio_q, audio_d;
  logic usb_det_q;
  logic clk_buf_en_q;
  logic digital_pd_q;

  assign shdn_wr = wr_in && (addr_in == `PRS_OFS_CTRL) && wdata_in[`PRS_CTRL_SHDN];

  // Merge every source into one asynchronous reset request
  assign src_b = rst_b_in && ext_reset_n_in && !core_supply_low_in
    && !lp_fire_q && !wd_fire_q;

  // Release is synchronous so no flop sees a ragged edge
  prs_rst_sync #(.STAGES(2)) u_sync (
    .clk_in(mclk_in),
    .arst_b_in(src_b),
    .rst_b_out(sys_rst_b)
  );

  // Regulator state: only power reset, shutdown or supply loss turn it off
  always_comb begin
    pwr_d = pwr_q;
    st_cnt_d = '0;
    loss_cnt_d = main_supply_in ? '0 : loss_cnt_q + 1'b1;
    case (pwr_q)
      prs_pkg::PRS_OFF: begin
        loss_cnt_d = '0;
        if (power_key_in) begin
          pwr_d = prs_pkg::PRS_STARTING;
          st_cnt_d = CNT_W'(1);
        end
      end
      prs_pkg::PRS_STARTING: begin
        loss_cnt_d = '0;
        st_cnt_d = st_cnt_q + 1'b1;
        if (!power_key_in) begin
          pwr_d = prs_pkg::PRS_OFF;
        end else if (st_cnt_q >= CNT_W'(START_CYC - 1)) begin
          pwr_d = prs_pkg::PRS_ON;
        end
      end
      prs_pkg::PRS_ON: begin
        // Key release does not leave this state
        if (shdn_wr || (!main_supply_in && loss_cnt_q >= CNT_W'(LOSS_CYC - 1))) begin
          pwr_d = prs_pkg::PRS_OFF;
        end
      end
      default: begin
        pwr_d = prs_pkg::PRS_OFF;
      end
    endcase
  end

  // Long press timer, also flags the firmware power-off hold
  always_comb begin
    lp_cnt_d = lp_cnt_q;
    lp_done_d = lp_done_q;
    lp_fire_d = 1'b0;
    if (!power_key_in || pwr_q != prs_pkg::PRS_ON) begin
      lp_cnt_d = '0;
      lp_done_d = 1'b0;
    end else if (!lp_done_q) begin
      lp_cnt_d = lp_cnt_q + 1'b1;
      if (lp_cnt_q >= CNT_W'(LONG_CYC - 1)) begin
        lp_fire_d = 1'b1;
        lp_done_d = 1'b1; // Fire once per press
      end
    end
  end

  // Watchdog expires when the count reaches one while enabled
  always_comb begin
    wd_fire_d = ctrl_wden_q && (wd_cnt_q == CNT_W'(1));
  end

  // Cause of the last reset, kept across internal resets
  always_comb begin
    cause_d = cause_q;
    if (core_supply_low_in || lp_fire_q || wd_fire_q || !ext_reset_n_in) begin
      cause_d = {!ext_reset_n_in, wd_fire_q, lp_fire_q, core_supply_low_in};
    end
  end

  // Always-on flops: only the power reset clears them
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_q <= prs_pkg::PRS_OFF;
      st_cnt_q <= '0;
      lp_cnt_q <= '0;
      loss_cnt_q <= '0;
      lp_done_q <= 1'b0;
      lp_fire_q <= 1'b0;
      wd_fire_q <= 1'b0;
      cause_q <= prs_pkg::PRS_CAUSE_NONE;
      rdata_q <= `PRS_RDATA_RST;
    end else begin
      pwr_q <= pwr_d;
      st_cnt_q <= st_cnt_d;
      lp_cnt_q <= lp_cnt_d;
      loss_cnt_q <= loss_cnt_d;
      lp_done_q <= lp_done_d;
      lp_fire_q <= lp_fire_d;
      wd_fire_q <= wd_fire_d;
      cause_q <= cause_d;
      rdata_q <= rdata_d;
    end
  end

  // Software registers; every internal reset reloads the defaults
  always_comb begin
    ctrl_usb_d = ctrl_usb_q;
    ctrl_wden_d = ctrl_wden_q;
    mul_d = mul_q;
    io33_d = io33_q;
    av36_d = av36_q;
    wd_cnt_d = (ctrl_wden_q && wd_cnt_q != '0) ? wd_cnt_q - 1'b1 : wd_cnt_q;
    if (wr_in) begin
      case (addr_in)
        `PRS_OFS_CTRL: begin
          ctrl_usb_d = wdata_in[`PRS_CTRL_USB];
          ctrl_wden_d = wdata_in[`PRS_CTRL_WDEN];
        end
        `PRS_OFS_CLKMUL: begin
          mul_d = wdata_in[`PRS_MUL_W-1:0];
        end
        `PRS_OFS_VREG: begin
          io33_d = wdata_in[`PRS_VREG_IO33];
          av36_d = wdata_in[`PRS_VREG_AV36];
        end
        `PRS_OFS_WDOG: begin
          wd_cnt_d = CNT_W'(wdata_in); // Kick reloads the count
        end
        default: begin
        end
      endcase
    end
  end

  // Effective multiplier: USB forces x4, player mode capped at x3.5
  always_comb begin
    if (ctrl_usb_q) begin
      clk_mult_d = `PRS_MUL_X4;
    end else if (mul_q > `PRS_MUL_X35) begin
      clk_mult_d = `PRS_MUL_X35;
    end else begin
      clk_mult_d = mul_q;
    end
  end

  always_ff @(posedge mclk_in or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      ctrl_usb_q <= 1'b0;
      ctrl_wden_q <= 1'b0;
      mul_q <= `PRS_MUL_X1;
      io33_q <= 1'b0;
      av36_q <= 1'b0;
      wd_cnt_q <= `PRS_WDOG_RST;
      clk_mult_q <= `PRS_MUL_X1;
    end else begin
      ctrl_usb_q <= ctrl_usb_d;
      ctrl_wden_q <= ctrl_wden_d;
      mul_q <= mul_d;
      io33_q <= io33_d;
      av36_q <= av36_d;
      wd_cnt_q <= wd_cnt_d;
      clk_mult_q <= clk_mult_d;
    end
  end

  // I/O and serial boot straps are caught on the first edge after the internal reset lifts; the USB class strap on a USB detect rise
  always_comb begin
    io_strap_d = rel_q ? io_strap_q : io_level_strap_in;
    spi_strap_d = rel_q ? spi_strap_q : spi_select_strap_in;
    audio_d = (usb_detect_in && !usb_det_q) ? usb_class_strap_in : audio_q;
  end

  always_ff @(posedge mclk_in or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      rel_q <= 1'b0;
      io_strap_q <= 1'b0;
      spi_strap_q <= 1'b0;
      audio_q <= 1'b0;
      usb_det_q <= 1'b0;
    end else begin
      rel_q <= 1'b1;
      io_strap_q <= io_strap_d;
      spi_strap_q <= spi_strap_d;
      audio_q <= audio_d;
      usb_det_q <= usb_detect_in;
    end
  end

  // External reset stops the clock buffer at once, without waiting for a clock
  always_ff @(posedge mclk_in or negedge ext_reset_n_in) begin
    if (!ext_reset_n_in) begin
      clk_buf_en_q <= 1'b0;
      digital_pd_q <= 1'b1;
    end else begin
      clk_buf_en_q <= 1'b1;
      digital_pd_q <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (rd_in) begin
      case (addr_in)
        `PRS_OFS_CTRL: begin
          rdata_d[`PRS_CTRL_USB] = ctrl_usb_q;
          rdata_d[`PRS_CTRL_WDEN] = ctrl_wden_q;
        end
        `PRS_OFS_STATUS: begin
          rdata_d[`PRS_ST_KEY] = power_key_in;
          rdata_d[`PRS_ST_HOLD] = lp_cnt_q >= CNT_W'(HOLD_CYC);
          rdata_d[`PRS_ST_IOSTRAP] = io_strap_q;
          rdata_d[`PRS_ST_SPISTRAP] = spi_strap_q;
          rdata_d[`PRS_ST_AUDIO] = audio_q;
          rdata_d[`PRS_ST_REGON] = pwr_q == prs_pkg::PRS_ON;
          rdata_d[`PRS_ST_CAUSE_LO+3:`PRS_ST_CAUSE_LO] = cause_q;
        end
        `PRS_OFS_CLKMUL: begin
          rdata_d[`PRS_MUL_W-1:0] = clk_mult_q;
        end
        `PRS_OFS_VREG: begin
          rdata_d[`PRS_VREG_IO33] = io33_q;
          rdata_d[`PRS_VREG_AV36] = av36_q;
        end
        `PRS_OFS_WDOG: begin
          rdata_d = 32'(wd_cnt_q);
        end
        default: begin
        end
      endcase
    end
  end

  assign rdata_out = rdata_q;
  assign regulators_on_out = pwr_q[2];
  assign sys_rst_b_out = sys_rst_b;
  assign clk_buf_en_out = clk_buf_en_q;
  assign digital_pd_out = digital_pd_q;
  assign clk_mult_out = clk_mult_q;
  assign io_33v_out = io33_q;
  assign analog_supply_36v_out = av36_q;
  assign boot_spi_out = spi_strap_q;
  assign usb_audio_out = audio_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  property p_start_key;
    $rose(regulators_on_out) |-> $past(power_key_in) && $past(power_key_in, 2);
  endproperty
  a_start_key: assert property (p_start_key) else $error("regulators on without key");
  property p_stay_on;
    regulators_on_out && !shdn_wr && main_supply_in |=> regulators_on_out;
  endproperty
  a_stay_on: assert property (p_stay_on) else $error("regulators dropped");
  property p_key_read;
    rd_in && addr_in == `PRS_OFS_STATUS |=> rdata_out[`PRS_ST_KEY] == $past(power_key_in);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key level misread");
  property p_core_low;
    core_supply_low_in |=> !sys_rst_b_out;
  endproperty
  a_core_low: assert property (p_core_low) else $error("no reset on low core");
  property p_long_press;
    lp_fire_q |=> !sys_rst_b_out ##1 !sys_rst_b_out;
  endproperty
  a_long_press: assert property (p_long_press) else $error("long press no reset");
  property p_ext_reset;
    !ext_reset_n_in |=> !sys_rst_b_out && !clk_buf_en_out && digital_pd_out;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("ext reset not applied");
  property p_shutdown;
    shdn_wr |=> !regulators_on_out;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown ignored");
  property p_usb_clk;
    sys_rst_b_out && ctrl_usb_q |=> !sys_rst_b_out || clk_mult_out == `PRS_MUL_X4;
  endproperty
  a_usb_clk: assert property (p_usb_clk) else $error("usb clock not x4");
  property p_player_cap;
    sys_rst_b_out && !ctrl_usb_q |=> !sys_rst_b_out || clk_mult_out <= `PRS_MUL_X35;
  endproperty
  a_player_cap: assert property (p_player_cap) else $error("player clock over cap");
  property p_lp_clear;
    !power_key_in |=> lp_cnt_q == '0;
  endproperty
  a_lp_clear: assert property (p_lp_clear) else $error("long press timer kept");
endmodule
`default_nettype wire

/* File: verification/prs_far_side.sv */
// Behavioural model of the power key, external reset pin and supply monitor
`timescale 1ns/100ps
`default_nettype none
module prs_far_side (
  input wire logic mclk_in, // Sequencer clock
  output logic power_key_out, // Key level, high while pressed
  output logic ext_reset_n_out, // External reset pin, active low
  output logic core_supply_low_out, // Monitor flag, core supply under level
  output logic main_supply_out // Main supply present
);
  // Idle state: key up, pin released high, both supplies good
  initial begin
    power_key_out = 1'b0;
    ext_reset_n_out = 1'b1;
    core_supply_low_out = 1'b0;
    main_supply_out = 1'b1;
  end
  // Key and mains move just after an edge, as a slow human or supply would
  task automatic key(input logic v);
    @(posedge mclk_in);
    power_key_out <= v;
  endtask
  task automatic mains(input logic v);
    @(posedge mclk_in);
    main_supply_out <= v;
  endtask
  // Pin and monitor move just after an edge too; only an asynchronous path reacts before the next
  task automatic ext(input logic v);
    @(posedge mclk_in);
    ext_reset_n_out <= v;
  endtask
  task automatic dip(input logic v);
    @(posedge mclk_in);
    core_supply_low_out <= v;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking testbench for the power, reset and clock sequencer
`timescale 1ns/100ps
`default_nettype none
`include "prs_params.svh"
module tb;
  localparam int ST = 8;
  localparam int LG = 40;
  localparam int HD = 20;
  localparam int LS = 6;
  logic mclk_in;
  logic rst_b_in;
  logic usb_det;
  logic io_strap;
  logic spi_strap;
  logic cls_strap;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic key, ext_n, core_low, mains;
  logic regs_on, sys_rst_b, clk_buf_en, dig_pd, io33, av36, boot_spi, usb_audio;
  logic [2:0] mult;
  logic [31:0] rdata, got;
  int n_fail = 0;
  int num_checks = 0;
  int rst_lows = 0;
  int base;
  // 125 MHz clock
  always #4 mclk_in = ~mclk_in;
  // Cycles spent in internal reset, used to prove that no reset happened
  always @(posedge mclk_in) if (sys_rst_b === 1'b0) rst_lows++;
  prs_far_side prs_far_side_inst (.mclk_in(mclk_in), .power_key_out(key),
    .ext_reset_n_out(ext_n), .core_supply_low_out(core_low), .main_supply_out(mains));
  prs_sequencer #(.START_CYC(ST), .LONG_CYC(LG), .HOLD_CYC(HD), .LOSS_CYC(LS))
  prs_sequencer_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .power_key_in(key),
    .ext_reset_n_in(ext_n), .core_supply_low_in(core_low), .main_supply_in(mains),
    .usb_detect_in(usb_det), .io_level_strap_in(io_strap), .spi_select_strap_in(spi_strap),
    .usb_class_strap_in(cls_strap), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .regulators_on_out(regs_on), .sys_rst_b_out(sys_rst_b),
    .clk_buf_en_out(clk_buf_en), .digital_pd_out(dig_pd), .clk_mult_out(mult),
    .io_33v_out(io33), .analog_supply_36v_out(av36), .boot_spi_out(boot_spi),
    .usb_audio_out(usb_audio));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // One-cycle strobes; the trailing delay lets registered outputs settle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(what, exp, d);
  endtask
  task automatic wait_rst(input logic lvl, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if (sys_rst_b === lvl) return;
      @(posedge mclk_in);
      #1;
    end
    chk("reset wait", {31'h0, lvl}, {31'h0, sys_rst_b});
    close_out();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic pwr_up();
    prs_far_side_inst.key(1'b1);
    cyc(ST + 2);
    chk("regulators on", 32'h1, {31'h0, regs_on});
    prs_far_side_inst.key(1'b0);
    cyc(3);
    chk("regulators held", 32'h1, {31'h0, regs_on});
  endtask
  // Main sequence
  initial begin
    mclk_in = 1'b0;
    rst_b_in <= 1'b0;
    usb_det <= 1'b0;
    io_strap <= 1'b1;
    spi_strap <= 1'b0;
    cls_strap <= 1'b0;
    addr <= 8'h00;
    wdata <= 32'h0000_0000;
    wr <= 1'b0;
    rd <= 1'b0;
    cyc(7);
    chk("reset during power reset", 32'h0, {31'h0, sys_rst_b});
    // Release on the eighth edge, so reset spans eight cycles
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    wait_rst(1'b1, 10);
    chk("off after power reset", 32'h0, {31'h0, regs_on});
    chk("io level", 32'h0, {31'h0, io33});
    chk("serial boot", 32'h0, {31'h0, boot_spi});
    rd_chk("status", `PRS_OFS_STATUS, 32'h0000_0004);
    prs_far_side_inst.key(1'b1);
    cyc(ST - 3);
    prs_far_side_inst.key(1'b0);
    cyc(ST + 4);
    chk("short press", 32'h0, {31'h0, regs_on});
    pwr_up();
    done("power up");
    base = rst_lows;
    prs_far_side_inst.key(1'b1);
    rd_chk("key level", `PRS_OFS_STATUS, 32'h0000_0025);
    cyc(HD + 2);
    rd_chk("hold flag", `PRS_OFS_STATUS, 32'h0000_0027);
    prs_far_side_inst.key(1'b0);
    prs_far_side_inst.key(1'b1);
    cyc(LG - 10);
    chk("interrupted press", base, rst_lows);
    wait_rst(1'b0, 20);
    prs_far_side_inst.key(1'b0);
    wait_rst(1'b1, 10);
    chk("regulators after long press", 32'h1, {31'h0, regs_on});
    rd_chk("long press cause", `PRS_OFS_STATUS, 32'h0000_0224);
    done("long press");
    for (int c = 0; c < 7; c++) begin
      wr_reg(`PRS_OFS_CLKMUL, c);
      // Effective code is registered once more after the request lands
      cyc(1);
      chk("player multiplier", (c > 5) ? 5 : c, {29'h0, mult});
    end
    rd_chk("multiplier readback", `PRS_OFS_CLKMUL, 32'h0000_0005);
    wr_reg(`PRS_OFS_CTRL, 32'h0000_0002);
    cyc(1);
    chk("usb multiplier", 32'h6, {29'h0, mult});
    wr_reg(`PRS_OFS_VREG, 32'h0000_0003);
    chk("io 3.3 V", 32'h1, {31'h0, io33});
    chk("analog 3.6 V", 32'h1, {31'h0, av36});
    rd_chk("vreg readback", `PRS_OFS_VREG, 32'h0000_0003);
    rd_chk("unmapped", 8'hFC, 32'h0000_0000);
    done("clock and voltage");
    prs_far_side_inst.dip(1'b1);
    #1 chk("supply reset", 32'h0, {31'h0, sys_rst_b});
    prs_far_side_inst.dip(1'b0);
    wait_rst(1'b1, 10);
    chk("regulators after dip", 32'h1, {31'h0, regs_on});
    chk("vreg reloaded", 32'h0, {30'h0, io33, av36});
    chk("multiplier reloaded", {29'h0, `PRS_MUL_X1}, {29'h0, mult});
    rd_chk("supply cause", `PRS_OFS_STATUS, 32'h0000_0124);
    done("supply monitor");
    // Flip both boot straps so the next release must catch new levels
    @(posedge mclk_in);
    spi_strap <= 1'b1;
    io_strap <= 1'b0;
    prs_far_side_inst.ext(1'b0);
    #1 chk("pin reset", 32'h0, {31'h0, sys_rst_b});
    chk("clock gated", 32'h0, {31'h0, clk_buf_en});
    chk("powerdown", 32'h1, {31'h0, dig_pd});
    prs_far_side_inst.ext(1'b1);
    wait_rst(1'b1, 10);
    // Straps are caught on the first edge after release
    cyc(1);
    chk("clock back", 32'h3, {30'h0, clk_buf_en, ~dig_pd});
    chk("serial boot strap", 32'h1, {31'h0, boot_spi});
    rd_chk("pin cause", `PRS_OFS_STATUS, 32'h0000_0828);
    done("external reset");
    wr_reg(`PRS_OFS_WDOG, 32'h0000_0005);
    wr_reg(`PRS_OFS_CTRL, 32'h0000_0004);
    wait_rst(1'b0, 20);
    wait_rst(1'b1, 10);
    rd_chk("watchdog cause", `PRS_OFS_STATUS, 32'h0000_0428);
    rd_chk("ctrl reloaded", `PRS_OFS_CTRL, 32'h0000_0000);
    done("watchdog");
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk_in);
      cls_strap <= v[0];
      usb_det <= 1'b1;
      cyc(3);
      chk("usb class", v, {31'h0, usb_audio});
      @(posedge mclk_in);
      usb_det <= 1'b0;
      cyc(2);
    end
    done("usb class");
    wr_reg(`PRS_OFS_CTRL, 32'h0000_0001);
    cyc(2);
    chk("shutdown bit", 32'h0, {31'h0, regs_on});
    pwr_up();
    prs_far_side_inst.mains(1'b0);
    cyc(LS - 3);
    prs_far_side_inst.mains(1'b1);
    cyc(3);
    chk("short mains loss", 32'h1, {31'h0, regs_on});
    prs_far_side_inst.mains(1'b0);
    cyc(LS + 3);
    chk("mains loss", 32'h0, {31'h0, regs_on});
    done("power off");
    close_out();
  end
endmodule
`default_nettype wire
